// ### logic/ebc_consts.svh
// Purpose: constants for the external bus control block
// Assumes: included by the design file only
// Notes: bit positions and encodings of the bus control register
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH
`define EBC_CTRL_ADDR 4'h0
`define EBC_CTRL_RESET 8'h00
`define EBC_CTRL_MASK 8'hB3
`define EBC_BIT_DIS 7
`define EBC_BIT_WAIT_HI 5
`define EBC_BIT_WAIT_LO 4
`define EBC_BIT_WM_HI 1
`define EBC_BIT_WM_LO 0
`define EBC_WAIT_MAX 2'h3
`define EBC_WM_BYTE_SEL 2'h1
`define EBC_WM_BYTE_WR 2'h0
`endif

// ### logic/ebc_pkg.sv
// Purpose: types for the external bus control block
// Assumes: nothing
// Notes: program memory modes and access phases
package ebc_pkg;
	typedef enum logic [1:0] {
		EBC_MODE_ONCHIP,
		EBC_MODE_EXT_MCU,
		EBC_MODE_MICROPROC,
		EBC_MODE_MP_BOOT
	} ebc_mode_e;
	typedef enum logic [1:0] {
		EBC_IDLE,
		EBC_WAIT,
		EBC_DONE
	} ebc_state_e;
endpackage

// ### logic/ebc_bus_control.sv
// Purpose: external memory bus control register, pin ownership, wait states, write strobes
// Assumes: ref_clk is the instruction clock; one table access at a time
// Notes: strobes active high; data out is byte-steered for 16-bit writes
`timescale 1ns/1ps
`default_nettype none
`include "ebc_consts.svh"
module ebc_bus_control (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire ebc_pkg::ebc_mode_e memMode,
	input wire logic wideBus,
	input wire logic accessReq,
	input wire logic accessWrite,
	input wire logic accessHigh,
	input wire logic [7:0] tableLatch,
	output logic accessDone,
	output logic busOwnsPins,
	output logic busActive,
	output logic [15:0] busDataOut,
	output logic highWriteStrobe,
	output logic lowWriteStrobe,
	output logic upperByteStrobe,
	output logic lowerByteStrobe
);
	import ebc_pkg::*;

	////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_q;
	ebc_state_e state_q;
	logic [1:0] waitCnt_q;
	logic writeOp_q;
	logic highOp_q;
	logic [7:0] latch_q;
	logic busDis;
	logic [1:0] waitField;
	logic [1:0] writeMode;
	logic [1:0] waitsNeeded;

	assign busDis = ctrl_q[`EBC_BIT_DIS];
	assign waitField = ctrl_q[`EBC_BIT_WAIT_HI:`EBC_BIT_WAIT_LO];
	assign writeMode = ctrl_q[`EBC_BIT_WM_HI:`EBC_BIT_WM_LO];
	// Field 11 means none, 00 means three
	assign waitsNeeded = `EBC_WAIT_MAX - waitField;

	// Pin owner from mode and disable bit; a request or access in progress overrides the disable bit
	function automatic logic ownsPins(input ebc_mode_e mode, input logic dis, input logic act);
		ownsPins = (mode != EBC_MODE_ONCHIP) && (!dis || act);
	endfunction

	////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_q <= `EBC_CTRL_RESET;
		end else if (regWrite && regAddr == `EBC_CTRL_ADDR && memMode != EBC_MODE_ONCHIP) begin
			// Mask keeps unimplemented bits at zero on every write
			ctrl_q <= regWdata & `EBC_CTRL_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regRdata <= 8'h00;
		end else if (regRead && regAddr == `EBC_CTRL_ADDR) begin
			regRdata <= ctrl_q;
		end else begin
			regRdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Access sequencer; memory must answer by the last wait cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= EBC_IDLE;
			waitCnt_q <= 2'h0;
			writeOp_q <= 1'b0;
			highOp_q <= 1'b0;
			latch_q <= 8'h00;
		end else begin
			// Requests outside IDLE are dropped, not queued
			case (state_q)
				EBC_IDLE: begin
					if (accessReq && memMode != EBC_MODE_ONCHIP) begin
						state_q <= EBC_WAIT;
						waitCnt_q <= waitsNeeded;
						writeOp_q <= accessWrite;
						highOp_q <= accessHigh;
						latch_q <= tableLatch;
					end
				end
				EBC_WAIT: begin
					if (waitCnt_q == 2'h0) begin
						state_q <= EBC_DONE;
					end else begin
						waitCnt_q <= waitCnt_q - 2'h1;
					end
				end
				EBC_DONE: begin
					state_q <= EBC_IDLE;
				end
				default: begin
					state_q <= EBC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			accessDone <= 1'b0;
			busActive <= 1'b0;
			busOwnsPins <= 1'b1;
		end else begin
			accessDone <= (state_q == EBC_WAIT) && (waitCnt_q == 2'h0);
			busActive <= (state_q == EBC_IDLE) ? (accessReq && memMode != EBC_MODE_ONCHIP) : (state_q == EBC_WAIT);
			busOwnsPins <= ownsPins(memMode, busDis, state_q != EBC_IDLE || accessReq);
		end
	end

	////////////////////////////////////////////////////////////////
	// Write data and strobes, held for the whole write cycle
	// Strobe stands every wait cycle, so slow parts see the widest pulse
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busDataOut <= 16'h0000;
			highWriteStrobe <= 1'b0;
			lowWriteStrobe <= 1'b0;
			upperByteStrobe <= 1'b0;
			lowerByteStrobe <= 1'b0;
		end else if (state_q == EBC_WAIT && writeOp_q) begin
			highWriteStrobe <= 1'b0;
			lowWriteStrobe <= 1'b0;
			upperByteStrobe <= 1'b0;
			lowerByteStrobe <= 1'b0;
			if (!wideBus) begin
				// Narrow bus: single byte, mode bits ignored
				busDataOut <= {8'h00, latch_q};
				lowWriteStrobe <= 1'b1;
			end else if (writeMode[1]) begin
				// Word mode: strobe only when high half lands
				if (highOp_q) begin
					busDataOut <= {latch_q, busDataOut[7:0]};
					highWriteStrobe <= 1'b1;
				end else begin
					busDataOut <= {busDataOut[15:8], latch_q};
				end
			end else if (writeMode == `EBC_WM_BYTE_SEL) begin
				busDataOut <= {latch_q, latch_q};
				highWriteStrobe <= 1'b1;
				upperByteStrobe <= highOp_q;
				lowerByteStrobe <= !highOp_q;
			end else begin
				busDataOut <= {latch_q, latch_q};
				highWriteStrobe <= highOp_q;
				lowWriteStrobe <= !highOp_q;
			end
		end else begin
			highWriteStrobe <= 1'b0;
			lowWriteStrobe <= 1'b0;
			upperByteStrobe <= 1'b0;
			lowerByteStrobe <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	AST_ONCHIP_LOCK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(memMode == EBC_MODE_ONCHIP) |=> $stable(ctrl_q)) else $error("register changed in on-chip mode");
	AST_ONCHIP_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_IDLE && memMode == EBC_MODE_ONCHIP) |=> !busActive)
		else $error("access taken in on-chip mode");
	AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ctrl_q & ~`EBC_CTRL_MASK) == 8'h00) else $error("reserved bits set");
	AST_BUS_OWNS: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!busDis && memMode != EBC_MODE_ONCHIP) |=> busOwnsPins) else $error("bus lost pins while enabled");
	AST_OVERRIDE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_WAIT && memMode != EBC_MODE_ONCHIP) |=> busOwnsPins) else $error("access without pins");
	AST_MODE_FREE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(memMode == EBC_MODE_ONCHIP) |=> !busOwnsPins) else $error("pins taken in on-chip mode");
	AST_NO_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_IDLE && accessReq && memMode != EBC_MODE_ONCHIP && waitField == 2'h3)
		|=> ##1 accessDone) else $error("zero-wait access late");
	AST_THREE_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_IDLE && accessReq && memMode != EBC_MODE_ONCHIP && waitField == 2'h0)
		|=> !accessDone [*4] ##1 accessDone) else $error("three-wait access wrong length");
	AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accessDone |=> !accessDone) else $error("done held longer than one cycle");
	AST_READ_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_WAIT && !writeOp_q) |=> !highWriteStrobe && !lowWriteStrobe)
		else $error("write strobe during a read");
	AST_WORD_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_WAIT && writeOp_q && wideBus && writeMode[1] && !highOp_q)
		|=> !highWriteStrobe && !lowWriteStrobe) else $error("strobe on low word half");
	AST_WORD_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_WAIT && writeOp_q && wideBus && writeMode[1] && highOp_q)
		|=> highWriteStrobe && busDataOut[15:8] == latch_q) else $error("high word half not strobed");
	AST_BYTE_SEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_WAIT && writeOp_q && wideBus && writeMode == `EBC_WM_BYTE_SEL)
		|=> highWriteStrobe && (upperByteStrobe != lowerByteStrobe)
		&& busDataOut[15:8] == busDataOut[7:0]) else $error("byte select strobes wrong");
	AST_BYTE_WR: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_WAIT && writeOp_q && wideBus && writeMode == `EBC_WM_BYTE_WR)
		|=> (highWriteStrobe != lowWriteStrobe) && !upperByteStrobe && !lowerByteStrobe
		&& busDataOut[15:8] == busDataOut[7:0]) else $error("byte write strobes wrong");
	AST_NARROW: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBC_WAIT && writeOp_q && !wideBus) |=> lowWriteStrobe && !highWriteStrobe)
		else $error("write mode acted on narrow bus");
endmodule
`default_nettype wire

// ### test/ebc_ext_mem.sv
// Purpose: far-side memory model for the external bus
// Assumes: write strobes active high
// Notes: keeps the last word written
`timescale 1ns/1ps
`default_nettype none
module ebc_ext_mem (
	input wire logic ref_clk,
	input wire logic busActive,
	input wire logic highWriteStrobe,
	input wire logic lowWriteStrobe,
	input wire logic [15:0] busDataOut,
	output logic [15:0] lastWord
);
	// Latches only inside the stretched cycle, never later
	always_ff @(posedge ref_clk) begin
		if (busActive && (highWriteStrobe || lowWriteStrobe)) begin
			lastWord <= busDataOut;
		end
	end
endmodule
`default_nettype wire

// ### test/ebc_bus_control_tb.sv
// Purpose: self-checking bench for the bus control block
// Assumes: control register at 4'h0
// Notes: strobe counts taken over the whole access
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module ebc_bus_control_tb;
	import ebc_pkg::*;
	logic ref_clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, wideBus = 1;
	logic accessReq = 0, accessWrite = 0, accessHigh = 0, own;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, tableLatch = 8'h00, regRdata;
	ebc_mode_e memMode = EBC_MODE_EXT_MCU;
	logic accessDone, busOwnsPins, busActive, highWriteStrobe, lowWriteStrobe, upperByteStrobe, lowerByteStrobe;
	logic [15:0] busDataOut, lastWord, dat;
	int n_errors = 0, total_checks = 0, cyc = 0, nHi, nLo, nUb, nLb, nEd, nAct;
	ebc_bus_control uut (.ref_clk, .sys_rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
		.memMode, .wideBus, .accessReq, .accessWrite, .accessHigh, .tableLatch, .accessDone,
		.busOwnsPins, .busActive, .busDataOut, .highWriteStrobe, .lowWriteStrobe,
		.upperByteStrobe, .lowerByteStrobe);
	ebc_ext_mem mem (.ref_clk, .busActive, .highWriteStrobe, .lowWriteStrobe, .busDataOut, .lastWord);
	////////////////////////////////////////////////////////////////
	always #5 ref_clk = ~ref_clk;
	// Whole run is just over a hundred cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			test_done();
		end
	end
	task test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		@(posedge ref_clk);
		regWrite <= 1'h0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge ref_clk);
		regRead <= 1'h0;
		#1 `CHK("regRdata", e, regRdata)
	endtask
	// Samples every cycle; bounded so a lost done cannot hang
	task acc(input logic w, input logic h, input logic [7:0] b);
		nHi = 0;
		nLo = 0;
		nUb = 0;
		nLb = 0;
		nAct = 0;
		@(posedge ref_clk);
		accessWrite <= w;
		accessHigh <= h;
		tableLatch <= b;
		accessReq <= 1'h1;
		@(posedge ref_clk);
		accessReq <= 1'h0;
		nEd = 1;
		#1 own = busOwnsPins;
		forever begin
			nHi += highWriteStrobe;
			nLo += lowWriteStrobe;
			nUb += upperByteStrobe;
			nLb += lowerByteStrobe;
			nAct += busActive;
			if (highWriteStrobe | lowWriteStrobe) dat = busDataOut;
			if (accessDone === 1'h1 || nEd > 8) break;
			@(posedge ref_clk);
			#1 nEd++;
		end
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task sx(input int h, input int l, input int u, input int b);
		`CHK("hiStrobe", h, nHi)
		`CHK("loStrobe", l, nLo)
		`CHK("ubStrobe", u, nUb)
		`CHK("lbStrobe", b, nLb)
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset();
		rd(4'h0, 8'h00);
		`CHK("own", 1'h1, busOwnsPins)
	endtask
	task t_regs();
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'hB3);
		rd(4'h5, 8'h00);
	endtask
	// Reads at every wait count, pins lent back when idle
	task t_waits();
		for (int w = 0; w < 4; w++) begin
			wr(4'h0, {2'h2, w[1:0], 4'h0});
			acc(1'h0, 1'h0, 8'h00);
			`CHK("edges", 5 - w, nEd)
			`CHK("active", 5 - w, nAct)
			sx(0, 0, 0, 0);
			`CHK("busOwn", 1'h1, own)
			`CHK("idleOwn", 1'h0, busOwnsPins)
		end
	endtask
	task t_byte();
		wr(4'h0, 8'h00);
		acc(1'h1, 1'h1, 8'h5A);
		sx(4, 0, 0, 0);
		`CHK("edges", 5, nEd)
		`CHK("data", 16'h5A5A, dat)
		`CHK("ownEn", 1'h1, busOwnsPins)
		wr(4'h0, 8'hB0);
		acc(1'h1, 1'h0, 8'hC3);
		sx(0, 1, 0, 0);
		`CHK("data", 16'hC3C3, dat)
		wr(4'h0, 8'hB1);
		acc(1'h1, 1'h1, 8'h5A);
		sx(1, 0, 1, 0);
		acc(1'h1, 1'h0, 8'hC3);
		sx(1, 0, 0, 1);
	endtask
	task t_word();
		wr(4'h0, 8'hB2);
		acc(1'h1, 1'h0, 8'h34);
		sx(0, 0, 0, 0);
		acc(1'h1, 1'h1, 8'h12);
		sx(1, 0, 0, 0);
		`CHK("word", 16'h1234, dat)
		`CHK("memWord", 16'h1234, lastWord)
	endtask
	task t_narrow();
		wr(4'h0, 8'hB1);
		wideBus <= 1'h0;
		memMode <= EBC_MODE_MICROPROC;
		acc(1'h1, 1'h1, 8'h77);
		sx(0, 1, 0, 0);
		`CHK("lowByte", 8'h77, dat[7:0])
		`CHK("highByte", 8'h00, dat[15:8])
	endtask
	// Register locked and requests dropped in on-chip mode
	task t_onchip();
		memMode <= EBC_MODE_ONCHIP;
		wr(4'h0, 8'h00);
		rd(4'h0, 8'hB1);
		`CHK("chipOwn", 1'h0, busOwnsPins)
		acc(1'h1, 1'h1, 8'h55);
		`CHK("refused", 9, nEd)
		`CHK("noActive", 0, nAct)
		sx(0, 0, 0, 0);
		`CHK("chipReq", 1'h0, own)
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'h0;
		t_reset();
		t_regs();
		t_waits();
		t_byte();
		t_word();
		t_narrow();
		t_onchip();
		test_done();
	end
endmodule
`default_nettype wire
